//--- dacr_regs.sv
`timescale 1ns/10ps
`default_nettype none
module dacr_regs
    import dacr_pkg::*;
#(
    parameter int CH_N = CH_MAX
) (
    input  wire logic            sys_clk,
    input  wire logic            rstn,
    input  wire dacr_axi_req_t   axi_req,
    output wire dacr_axi_rsp_t   axi_rsp,
    input  wire logic [CH_N-1:0] periph_req,
    output var  dacr_xfer_t      xfer_r,
    input  wire logic            xfer_ack,
    output var  logic [CH_N-1:0] done_r,
    output var  logic            irq_r
);

    if (CH_N < 1 || CH_N > CH_MAX) begin : g_bad
        $error("CH_N must lie between 1 and 4");
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] d,
        input logic [3:0]  s
    );
        merge16 = old;
        if (s[0]) merge16[7:0] = d[7:0];
        if (s[1]) merge16[15:8] = d[15:8];
    endfunction : merge16

    function automatic logic addr_ok(input logic [7:0] a);
        if (a[1:0] != 2'h0)
            addr_ok = 1'b0;
        else if (!a[7])
            addr_ok = int'(a[6:5]) < CH_N;
        else
            addr_ok = a <= OFF_IMASK;
    endfunction : addr_ok

    logic [15:0]        channel_control_r      [CH_N];
    logic [15:0]        channel_request_sel_r  [CH_N];
    logic [15:0]        start_a_high_r         [CH_N];
    logic [15:0]        start_a_low_r          [CH_N];
    logic [15:0]        start_b_high_r         [CH_N];
    logic [15:0]        start_b_low_r          [CH_N];
    logic [15:0]        channel_peripheral_address_r [CH_N];
    logic [COUNT_W-1:0] channel_transfer_count_r [CH_N];
    logic [COUNT_W-1:0] idx_r                  [CH_N];
    logic               pending_r              [CH_N];
    wire  [CH_N-1:0]    ready_ch;
    wire  [CH_N-1:0]    ack_hit;
    wire  [CH_N-1:0]    last_hit;
    wire  [CH_N-1:0]    ch_we;
    wire  [CH_N-1:0]    pwc_set;
    wire  [CH_N-1:0]    rqc_set;
    logic [CH_N-1:0]    pwc_r;
    logic [CH_N-1:0]    rqc_r;
    logic [CH_N-1:0]    istat_r;
    logic [CH_N-1:0]    imask_r;
    logic [1:0]         lca_r;
    logic [RADR_W-1:0]  last_ram_address_r;
    dacr_state_t        state_r;
    logic               sel_v;
    logic [1:0]         sel_ch;
    logic               ack_v;

    // AXI4-Lite write side
    logic        aw_full_r;
    logic        w_full_r;
    logic        awready_r;
    logic        wready_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        wr_go;
    logic        wr_en;

    assign wr_go = aw_full_r & w_full_r & ~bvalid_r;
    assign wr_en = wr_go & addr_ok(awaddr_r);

    // Address and data are parked separately so either may come first
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            if (axi_req.awvalid && awready_r) begin
                aw_full_r <= 1'b1;
                awready_r <= 1'b0;
                awaddr_r  <= axi_req.awaddr;
            end
            if (axi_req.wvalid && wready_r) begin
                w_full_r <= 1'b1;
                wready_r <= 1'b0;
                wdata_r  <= axi_req.wdata;
                wstrb_r  <= axi_req.wstrb;
            end
            if (wr_go) begin
                aw_full_r <= 1'b0;
                w_full_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= addr_ok(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_r && axi_req.bready) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // Per-channel register sets and transfer bookkeeping
    for (genvar c = 0; c < CH_N; c++) begin : g_ch
        assign ch_we[c]    = wr_en && !awaddr_r[7] && awaddr_r[6:5] == 2'(c);
        assign ready_ch[c] = pending_r[c] & channel_control_r[c][CTL_EN];
        assign ack_hit[c]  = ack_v && xfer_r.chan == 2'(c);
        // Zero programmed still gives one transfer
        assign last_hit[c] = idx_r[c] == channel_transfer_count_r[c];
        // Flags a hazardous rewrite of a live channel's peripheral address or transfer count
        assign pwc_set[c]  = ch_we[c] && channel_control_r[c][CTL_EN]
            && (awaddr_r[4:0] == OFF_PERIPH
            || awaddr_r[4:0] == OFF_COUNT);
        assign rqc_set[c]  = periph_req[c] && ready_ch[c] && !ack_hit[c];

        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                channel_control_r[c]            <= RST_16;
                channel_request_sel_r[c]        <= RST_16;
                start_a_high_r[c]               <= RST_16;
                start_a_low_r[c]                <= RST_16;
                start_b_high_r[c]               <= RST_16;
                start_b_low_r[c]                <= RST_16;
                channel_peripheral_address_r[c] <= RST_16;
                channel_transfer_count_r[c]     <= '0;
                idx_r[c]                        <= '0;
            end else begin
                if (ch_we[c]) begin
                    case (awaddr_r[4:0])
                        OFF_CTL: begin
                            channel_control_r[c] <= merge16(
                                channel_control_r[c], wdata_r, wstrb_r);
                        end
                        OFF_REQSEL: begin
                            channel_request_sel_r[c] <= merge16(
                                channel_request_sel_r[c], wdata_r, wstrb_r);
                        end
                        OFF_STAH: begin
                            start_a_high_r[c] <= merge16(
                                start_a_high_r[c], wdata_r, wstrb_r);
                        end
                        OFF_STAL: begin
                            start_a_low_r[c] <= merge16(
                                start_a_low_r[c], wdata_r, wstrb_r);
                        end
                        OFF_STBH: begin
                            start_b_high_r[c] <= merge16(
                                start_b_high_r[c], wdata_r, wstrb_r);
                        end
                        OFF_STBL: begin
                            start_b_low_r[c] <= merge16(
                                start_b_low_r[c], wdata_r, wstrb_r);
                        end
                        OFF_PERIPH: begin
                            channel_peripheral_address_r[c] <= merge16(
                                channel_peripheral_address_r[c],
                                wdata_r, wstrb_r);
                        end
                        OFF_COUNT: begin
                            channel_transfer_count_r[c] <= COUNT_W'(merge16(
                                {2'h0, channel_transfer_count_r[c]},
                                wdata_r, wstrb_r));
                            idx_r[c] <= '0;
                        end
                        default: begin
                        end
                    endcase
                end
                // Completion wins over a same-cycle control write
                if (ack_hit[c]) begin
                    if (last_hit[c]) begin
                        idx_r[c] <= '0;
                        channel_control_r[c][CTL_EN] <= 1'b0;
                    end else begin
                        idx_r[c] <= idx_r[c] + 14'h0001;
                    end
                end
            end
        end

        // A request landing in the ack cycle is kept as the next one
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn)
                pending_r[c] <= 1'b0;
            else if (!channel_control_r[c][CTL_EN])
                pending_r[c] <= 1'b0;
            else if (periph_req[c])
                pending_r[c] <= 1'b1;
            else if (ack_hit[c])
                pending_r[c] <= 1'b0;
        end

        a_done_cause: assert property (
            done_r[c] |-> $past(ack_hit[c]) && $past(last_hit[c]))
            else $error("done without final acknowledged transfer");
        a_done_stops: assert property (
            done_r[c] |-> !channel_control_r[c][CTL_EN])
            else $error("channel still enabled after completion");
        a_periph_hold: assert property (
            !$stable(channel_peripheral_address_r[c]) |-> $past(ch_we[c]))
            else $error("peripheral address changed without a write");
        a_start_write: assert property (
            ch_we[c] && awaddr_r[4:0] == OFF_STAH && wstrb_r[1:0] == 2'h3
            |=> start_a_high_r[c] == $past(wdata_r[15:0]))
            else $error("start address high not written");
        a_rqc_sticky: assert property (
            rqc_set[c] |=> rqc_r[c])
            else $error("request collision not recorded");
        a_irq_raise: assert property (
            done_r[c] && imask_r[c] |-> ##1 irq_r)
            else $error("unmasked completion gave no interrupt");
    end

    // Fixed priority: lowest channel number first
    always_comb begin
        sel_v  = 1'b0;
        sel_ch = 2'h0;
        for (int i = CH_N - 1; i >= 0; i--) begin
            if (ready_ch[i]) begin
                sel_v  = 1'b1;
                sel_ch = 2'(i);
            end
        end
    end

    assign ack_v = state_r == ST_WAIT && xfer_ack;

    // Only start address A is walked; ping-pong is not modelled
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r            <= ST_IDLE;
            xfer_r             <= '0;
            lca_r              <= 2'h0;
            last_ram_address_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (sel_v) begin
                        xfer_r.valid       <= 1'b1;
                        xfer_r.chan        <= sel_ch;
                        xfer_r.ram_addr    <= {start_a_high_r[sel_ch][7:0],
                            start_a_low_r[sel_ch]}
                            + {10'h000, idx_r[sel_ch]};
                        xfer_r.periph_addr <=
                            channel_peripheral_address_r[sel_ch];
                        state_r            <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (xfer_ack) begin
                        xfer_r.valid       <= 1'b0;
                        lca_r              <= xfer_r.chan;
                        last_ram_address_r <= xfer_r.ram_addr;
                        state_r            <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    a_xfer_hold: assert property (
        xfer_r.valid && !xfer_ack |=> xfer_r.valid
            && $stable(xfer_r.ram_addr))
        else $error("transfer request dropped before acknowledge");
    a_last_track: assert property (
        ack_v |=> last_ram_address_r == $past(xfer_r.ram_addr))
        else $error("last RAM address not captured");

    // Sticky status: set beats a same-cycle write-one clear
    logic [CH_N-1:0] wclr;
    assign wclr = wdata_r[CH_N-1:0] & {CH_N{wstrb_r[0]}};

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pwc_r   <= '0;
            rqc_r   <= '0;
            istat_r <= '0;
            imask_r <= '0;
            done_r  <= '0;
            irq_r   <= 1'b0;
        end else begin
            pwc_r <= (pwc_r & ~((wr_en && awaddr_r == OFF_PWC)
                ? wclr : '0)) | pwc_set;
            rqc_r <= (rqc_r & ~((wr_en && awaddr_r == OFF_RQC)
                ? wclr : '0)) | rqc_set;
            istat_r <= (istat_r & ~((wr_en && awaddr_r == OFF_ISTAT)
                ? wclr : '0)) | (ack_hit & last_hit);
            if (wr_en && awaddr_r == OFF_IMASK && wstrb_r[0])
                imask_r <= wdata_r[CH_N-1:0];
            done_r <= ack_hit & last_hit;
            irq_r  <= |(istat_r & imask_r);
        end
    end

    // AXI4-Lite read side
    logic        arready_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic [7:0]  rd_addr_r;
    logic [15:0] rd_data;
    logic [7:0]  ra;
    logic [1:0]  rch;

    assign ra  = axi_req.araddr;
    assign rch = ra[6:5];

    always_comb begin
        rd_data = 16'h0000;
        if (addr_ok(ra) && !ra[7]) begin
            case (ra[4:0])
                OFF_CTL:    rd_data = channel_control_r[rch];
                OFF_REQSEL: rd_data = channel_request_sel_r[rch];
                OFF_STAH:   rd_data = start_a_high_r[rch];
                OFF_STAL:   rd_data = start_a_low_r[rch];
                OFF_STBH:   rd_data = start_b_high_r[rch];
                OFF_STBL:   rd_data = start_b_low_r[rch];
                OFF_PERIPH: rd_data = channel_peripheral_address_r[rch];
                OFF_COUNT:  rd_data = {2'h0,
                    channel_transfer_count_r[rch]};
                default:    rd_data = 16'h0000;
            endcase
        end else if (addr_ok(ra)) begin
            case (ra)
                OFF_PWC:   rd_data = 16'(pwc_r);
                OFF_RQC:   rd_data = 16'(rqc_r);
                OFF_LCA:   rd_data = {14'h0000, lca_r};
                OFF_SADH:  rd_data = {8'h00,
                    last_ram_address_r[23:16]};
                OFF_SADL:  rd_data = last_ram_address_r[15:0];
                OFF_ISTAT: rd_data = 16'(istat_r);
                OFF_IMASK: rd_data = 16'(imask_r);
                default:   rd_data = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= RESP_OKAY;
            rd_addr_r <= 8'h00;
        end else begin
            if (axi_req.arvalid && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= {16'h0000, rd_data};
                rresp_r   <= addr_ok(ra) ? RESP_OKAY : RESP_SLVERR;
                rd_addr_r <= ra;
            end
            if (rvalid_r && axi_req.rready) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    a_count_top: assert property (
        rvalid_r && !rd_addr_r[7] && rd_addr_r[4:0] == OFF_COUNT
        |-> rdata_r[15:14] == 2'h0)
        else $error("count upper bits read nonzero");
    a_high_zero: assert property (
        rvalid_r && rd_addr_r == OFF_SADH |-> rdata_r[31:8] == 24'h000000)
        else $error("last address high upper byte nonzero");
    a_width16: assert property (
        rvalid_r |-> rdata_r[31:16] == 16'h0000)
        else $error("register read wider than 16 bits");

    assign axi_rsp = '{awready: awready_r, wready: wready_r,
        bvalid: bvalid_r, bresp: bresp_r, arready: arready_r,
        rvalid: rvalid_r, rdata: rdata_r, rresp: rresp_r};

endmodule : dacr_regs
`default_nettype wire

//--- dacr_pkg.sv
`default_nettype none
package dacr_pkg;
    localparam int         CH_MAX      = 4;
    localparam int         COUNT_W     = 14;
    localparam int         RADR_W      = 24;
    localparam int         CTL_EN      = 15;
    localparam logic [15:0] RST_16     = 16'h0000;
    localparam logic [4:0] OFF_CTL     = 5'h00;
    localparam logic [4:0] OFF_REQSEL  = 5'h04;
    localparam logic [4:0] OFF_STAH    = 5'h08;
    localparam logic [4:0] OFF_STAL    = 5'h0c;
    localparam logic [4:0] OFF_STBH    = 5'h10;
    localparam logic [4:0] OFF_STBL    = 5'h14;
    localparam logic [4:0] OFF_PERIPH  = 5'h18;
    localparam logic [4:0] OFF_COUNT   = 5'h1c;
    localparam logic [7:0] OFF_PWC     = 8'h80;
    localparam logic [7:0] OFF_RQC     = 8'h84;
    localparam logic [7:0] OFF_PPS     = 8'h88;
    localparam logic [7:0] OFF_LCA     = 8'h8c;
    localparam logic [7:0] OFF_SADH    = 8'h90;
    localparam logic [7:0] OFF_SADL    = 8'h94;
    localparam logic [7:0] OFF_ISTAT   = 8'h98;
    localparam logic [7:0] OFF_IMASK   = 8'h9c;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {ST_IDLE, ST_WAIT} dacr_state_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } dacr_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } dacr_axi_rsp_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  chan;
        logic [23:0] ram_addr;
        logic [15:0] periph_addr;
    } dacr_xfer_t;
endpackage : dacr_pkg
`default_nettype wire

//--- dacr_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module dacr_bus_model
    import dacr_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire dacr_xfer_t xfer,
    output var  logic       xfer_ack
);
    logic [1:0] wait_r;
    logic       slow_r;

    // Alternates prompt and slow completion so both ack timings occur
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wait_r   <= 2'h0;
            slow_r   <= 1'b0;
            xfer_ack <= 1'b0;
        end else if (xfer_ack) begin
            xfer_ack <= 1'b0;
            slow_r   <= ~slow_r;
        end else if (xfer.valid) begin
            if (wait_r == (slow_r ? 2'h3 : 2'h0)) begin
                xfer_ack <= 1'b1;
                wait_r   <= 2'h0;
            end else begin
                wait_r <= wait_r + 2'h1;
            end
        end
    end
endmodule : dacr_bus_model
`default_nettype wire

//--- dma_channel_address_count_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module dma_channel_address_count_regs_tb_top
    import dacr_pkg::*;
;
    logic          sys_clk    = 1'b0;
    logic          rstn       = 1'b0;
    dacr_axi_req_t axi_req    = '0;
    dacr_axi_rsp_t axi_rsp;
    logic [3:0]    periph_req = 4'h0;
    dacr_xfer_t    xfer_r;
    logic          xfer_ack;
    logic [3:0]    done_r;
    logic          irq_r;
    int            n_mismatch = 0;
    int            total_checks = 0;
    int            done_cnt   = 0;
    logic [31:0]   seed       = 32'hf296b060;
    logic [1:0]    q_b[$];
    logic [33:0]   q_r[$];
    logic [41:0]   q_x[$];

    always #2.5 sys_clk = ~sys_clk;

    dacr_regs #(.CH_N(4)) u_dut (.sys_clk(sys_clk), .rstn(rstn),
        .axi_req(axi_req), .axi_rsp(axi_rsp), .periph_req(periph_req),
        .xfer_r(xfer_r), .xfer_ack(xfer_ack), .done_r(done_r),
        .irq_r(irq_r));
    dacr_bus_model u_bus (.sys_clk(sys_clk), .rstn(rstn), .xfer(xfer_r),
        .xfer_ack(xfer_ack));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [7:0] ra(int c, logic [4:0] off);
        return 8'(c * 32) | {3'h0, off};
    endfunction : ra

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic fail_wait(string n);
        $display("BAD %s exp answer got none", n);
        n_mismatch++;
        report_and_stop();
    endtask : fail_wait

    task automatic cmp_resp(string n, logic [1:0] e, logic [1:0] s);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : cmp_resp

    task automatic cmp_word(string n, logic [33:0] e, logic [33:0] s);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : cmp_word

    task automatic cmp_xfer(string n, logic [41:0] e, logic [41:0] s);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : cmp_xfer

    // Results are compared in the order they appear at the ports
    always @(posedge sys_clk) begin
        if (rstn) begin
            if (axi_req.bready && axi_rsp.bvalid)
                cmp_resp("bresp", q_b.pop_front(),
                         axi_rsp.bresp);
            if (axi_req.rready && axi_rsp.rvalid)
                cmp_word("rdata", q_r.pop_front(),
                         {axi_rsp.rresp, axi_rsp.rdata});
            if (xfer_r.valid && xfer_ack)
                cmp_xfer("xfer", q_x.pop_front(), {xfer_r.chan,
                         xfer_r.periph_addr, xfer_r.ram_addr});
            done_cnt = done_cnt + $countones(done_r);
        end
    end

    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        bit done;
        done = 1'b0;
        q_b.push_back(er);
        @(posedge sys_clk);
        axi_req.awaddr  <= a;
        axi_req.wdata   <= d;
        axi_req.wstrb   <= 4'hf;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid  <= 1'b1;
        axi_req.bready  <= 1'b1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(posedge sys_clk);
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
            if (axi_rsp.bvalid) begin
                axi_req.bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) fail_wait("bvalid");
    endtask : wr

    task automatic rd(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        bit done;
        done = 1'b0;
        q_r.push_back({er, d});
        @(posedge sys_clk);
        axi_req.araddr  <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready  <= 1'b1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(posedge sys_clk);
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
            if (axi_rsp.rvalid) begin
                axi_req.rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) fail_wait("rvalid");
    endtask : rd

    task automatic req(int c, logic [41:0] ex, int hold = 1);
        bit done;
        done = 1'b0;
        q_x.push_back(ex);
        @(posedge sys_clk);
        periph_req[c] <= 1'b1;
        repeat (hold) @(posedge sys_clk);
        periph_req[c] <= 1'b0;
        for (int i = 0; i < 40 && !done; i++) begin
            @(posedge sys_clk);
            done = xfer_r.valid && xfer_ack;
        end
        if (!done) fail_wait("xfer_ack");
    endtask : req

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_wait("run");
    end

    initial begin
        logic [31:0] v;
        logic [31:0] hi;
        logic [31:0] lo;
        logic [23:0] base;
        int          n;
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(ra(0, OFF_PERIPH), 32'h0, RESP_OKAY);
        rd(ra(3, OFF_COUNT), 32'h0, RESP_OKAY);
        rd(OFF_SADH, 32'h0, RESP_OKAY);
        rd(OFF_SADL, 32'h0, RESP_OKAY);
        for (int c = 0; c < 4; c++) begin
            v = xs();
            wr(ra(c, OFF_PERIPH), v, RESP_OKAY);
            wr(ra(c, OFF_COUNT), 32'hffff_ffff, RESP_OKAY);
            rd(ra(c, OFF_PERIPH), {16'h0, v[15:0]}, RESP_OKAY);
            rd(ra(c, OFF_COUNT), 32'h3fff, RESP_OKAY);
            wr(ra(c, OFF_REQSEL), ~v, RESP_OKAY);
            rd(ra(c, OFF_REQSEL), {16'h0, ~v[15:0]}, RESP_OKAY);
            wr(ra(c, OFF_STBL), v, RESP_OKAY);
            rd(ra(c, OFF_STBL), {16'h0, v[15:0]}, RESP_OKAY);
        end
        rd(8'ha0, 32'h0, RESP_SLVERR);
        wr(8'ha0, 32'h1, RESP_SLVERR);
        wr(OFF_IMASK, 32'h2, RESP_OKAY);
        for (int c = 1; c < 3; c++) begin
            n = (c == 1) ? 2 : 0;
            hi = xs();
            lo = xs();
            v = xs();
            base = {hi[7:0], lo[15:0]};
            // Set up fully while disabled; writes to a live channel are unsafe
            wr(ra(c, OFF_STAH), hi, RESP_OKAY);
            wr(ra(c, OFF_STAL), lo, RESP_OKAY);
            wr(ra(c, OFF_PERIPH), v, RESP_OKAY);
            wr(ra(c, OFF_COUNT), 32'(n), RESP_OKAY);
            wr(ra(c, OFF_CTL), 32'h8000, RESP_OKAY);
            done_cnt = 0;
            for (int k = 0; k <= n; k++)
                req(c, {2'(c), v[15:0], base + 24'(k)});
            repeat (3) @(posedge sys_clk);
            cmp_word("done", 34'h1, 34'(done_cnt));
            cmp_word("irq", {33'h0, c == 1}, {33'h0, irq_r});
            base = base + 24'(n);
            rd(OFF_SADH, {24'h0, base[23:16]}, RESP_OKAY);
            rd(OFF_SADL, {16'h0, base[15:0]}, RESP_OKAY);
            rd(OFF_LCA, 32'(c), RESP_OKAY);
            rd(ra(c, OFF_CTL), 32'h0, RESP_OKAY);
            rd(OFF_ISTAT, 32'h1 << c, RESP_OKAY);
            wr(OFF_ISTAT, 32'h1 << c, RESP_OKAY);
            repeat (2) @(posedge sys_clk);
            cmp_word("irq", 34'h0, {33'h0, irq_r});
        end
        rd(OFF_ISTAT, 32'h0, RESP_OKAY);
        rd(OFF_PPS, 32'h0, RESP_OKAY);
        // Rewriting a live channel's address must be flagged
        v = xs();
        wr(ra(0, OFF_CTL), 32'h8000, RESP_OKAY);
        wr(ra(0, OFF_PERIPH), v, RESP_OKAY);
        rd(OFF_PWC, 32'h1, RESP_OKAY);
        // A request held two cycles lands on its own pending one
        req(0, {2'h0, v[15:0], 24'h0}, 2);
        rd(OFF_RQC, 32'h1, RESP_OKAY);
        wr(OFF_PWC, 32'h1, RESP_OKAY);
        wr(OFF_RQC, 32'h1, RESP_OKAY);
        rd(OFF_PWC, 32'h0, RESP_OKAY);
        rd(OFF_RQC, 32'h0, RESP_OKAY);
        report_and_stop();
    end
endmodule : dma_channel_address_count_regs_tb_top
`default_nettype wire
